// ### src/setws_eeprom_slave.sv
// Two-wire serial EEPROM slave with page buffer, timed programming and Avalon-MM status port
`timescale 1ns/1ns
module setws_eeprom_slave #(
    parameter int WRITE_CYCLES = setws_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Two-wire bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // Straps
    input wire logic [2:0] deviceSelectStraps,
    input wire logic writeInhibit,
    // Avalon-MM slave
    input wire setws_pkg::setws_avs_req_t avsReq,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest
);

    if (WRITE_CYCLES <= setws_pkg::PAGE_BYTES || WRITE_CYCLES > 262144) begin : g_bad_write_cycles
        $error("WRITE_CYCLES must exceed the page size and fit the 18-bit counter");
    end

    localparam logic [17:0] BUSY_LOAD = 18'(WRITE_CYCLES - 1);

    // Reset release
    logic rstMeta;
    logic rstSync;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Bus edge and condition detection
    logic sclPrev;
    logic sdaPrev;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclIn;
            sdaPrev <= sdaIn;
        end
    end

    assign sclRise = sclIn && !sclPrev;
    assign sclFall = !sclIn && sclPrev;
    assign startDet = sclIn && sclPrev && sdaPrev && !sdaIn;
    assign stopDet = sclIn && sclPrev && !sdaPrev && sdaIn;

    // Any event after which the data line may legally move
    logic lineEvent;
    assign lineEvent = sclFall || startDet || stopDet;

    // Protocol state
    setws_pkg::setws_state_t state;
    logic [3:0] bitCnt;
    logic ackPhase;
    logic [7:0] shiftIn;
    logic [7:0] outByte;
    logic masterAck;
    logic [setws_pkg::ADDR_W-1:0] addr;
    logic [7:0] addrHi;
    logic pending;
    logic busy;
    logic [17:0] busyCnt;
    logic [7:0] progIdx;
    logic [setws_pkg::ROW_W-1:0] pageRow;
    logic [setws_pkg::PAGE_BYTES-1:0] pageMask;
    logic [31:0] controlReg;
    logic protectEff;
    logic byteDone;
    logic ackEnd;
    logic devMatch;
    logic readGo;
    logic progStart;

    logic [7:0] mem [0:setws_pkg::PAGE_COUNT*setws_pkg::PAGE_BYTES-1];
    logic [7:0] pageBuf [0:setws_pkg::PAGE_BYTES-1];

    assign protectEff = writeInhibit || controlReg[setws_pkg::CTRL_SOFT_PROTECT];
    assign byteDone = sclFall && !ackPhase && (bitCnt == 4'h8) && (state != setws_pkg::ST_IDLE);
    assign ackEnd = sclFall && ackPhase;
    assign devMatch = (shiftIn[7:4] == setws_pkg::TYPE_PATTERN)
        && (shiftIn[3:1] == deviceSelectStraps)
        && !busy;
    assign readGo = ackEnd && (state == setws_pkg::ST_RDAT) && masterAck;
    assign progStart = stopDet && (state == setws_pkg::ST_WDAT) && pending && !protectEff && !busy;

    // Main sequencer
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            state <= setws_pkg::ST_IDLE;
        end else if (startDet) begin
            state <= setws_pkg::ST_DEV;
        end else if (stopDet) begin
            state <= setws_pkg::ST_IDLE;
        end else if (byteDone) begin
            unique case (state)
                setws_pkg::ST_DEV: begin
                    if (!devMatch) begin
                        state <= setws_pkg::ST_IDLE;
                    end else if (shiftIn[0]) begin
                        state <= setws_pkg::ST_RDAT;
                    end else begin
                        state <= setws_pkg::ST_AHI;
                    end
                end
                setws_pkg::ST_AHI: state <= setws_pkg::ST_ALO;
                setws_pkg::ST_ALO: state <= setws_pkg::ST_WDAT;
                setws_pkg::ST_WDAT: state <= setws_pkg::ST_WDAT;
                setws_pkg::ST_RDAT: state <= setws_pkg::ST_RDAT;
                default: state <= setws_pkg::ST_IDLE;
            endcase
        end else if (ackEnd && (state == setws_pkg::ST_RDAT) && !masterAck) begin
            state <= setws_pkg::ST_IDLE;
        end
    end

    // Bit and acknowledge sequencing
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
            shiftIn <= 8'h00;
            masterAck <= 1'b0;
        end else if (startDet || stopDet) begin
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
        end else if (state == setws_pkg::ST_IDLE) begin
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
        end else if (sclRise && !ackPhase && (bitCnt < 4'h8)) begin
            shiftIn <= {shiftIn[6:0], sdaIn};
            bitCnt <= bitCnt + 4'h1;
        end else if (sclRise && ackPhase) begin
            masterAck <= !sdaIn;
        end else if (byteDone) begin
            ackPhase <= !((state == setws_pkg::ST_DEV) && !devMatch);
            if ((state == setws_pkg::ST_DEV) && shiftIn[0]) begin
                masterAck <= 1'b1;
            end
        end else if (ackEnd) begin
            ackPhase <= 1'b0;
            bitCnt <= 4'h0;
        end
    end

    // Data line driver, open-drain only
    assign sdaOut = 1'b0;

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            sdaOeN <= 1'b1;
        end else if (startDet || stopDet) begin
            sdaOeN <= 1'b1;
        end else if (byteDone) begin
            if (state == setws_pkg::ST_RDAT) begin
                sdaOeN <= 1'b1;
            end else if ((state == setws_pkg::ST_DEV) && !devMatch) begin
                sdaOeN <= 1'b1;
            end else begin
                sdaOeN <= 1'b0;
            end
        end else if (ackEnd) begin
            sdaOeN <= readGo ? mem[addr][7] : 1'b1;
        end else if (sclFall && (state == setws_pkg::ST_RDAT) && !ackPhase && (bitCnt != 4'h0)
                     && (bitCnt < 4'h8)) begin
            sdaOeN <= outByte[3'(4'h7 - bitCnt)];
        end
    end

    // Address counter and read data
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            addr <= '0;
            addrHi <= 8'h00;
            outByte <= 8'h00;
        end else if (byteDone && (state == setws_pkg::ST_AHI)) begin
            addrHi <= shiftIn;
        end else if (byteDone && (state == setws_pkg::ST_ALO)) begin
            addr <= {addrHi, shiftIn};
        end else if (byteDone && (state == setws_pkg::ST_WDAT)) begin
            addr <= {addr[setws_pkg::ADDR_W-1:setws_pkg::OFFSET_W],
                     addr[setws_pkg::OFFSET_W-1:0] + 7'h01};
        end else if (readGo) begin
            outByte <= mem[addr];
            addr <= addr + 16'h0001;
        end
    end

    // Page buffer bookkeeping
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            pending <= 1'b0;
            pageMask <= '0;
        end else if (byteDone && (state == setws_pkg::ST_ALO)) begin
            pending <= 1'b0;
            pageMask <= '0;
        end else if (byteDone && (state == setws_pkg::ST_WDAT)) begin
            pending <= 1'b1;
            pageMask[addr[setws_pkg::OFFSET_W-1:0]] <= 1'b1;
        end else if (stopDet || startDet) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (byteDone && (state == setws_pkg::ST_WDAT)) begin
            pageBuf[addr[setws_pkg::OFFSET_W-1:0]] <= shiftIn;
        end
    end

    // Timed programming cycle
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            busy <= 1'b0;
            busyCnt <= 18'h00000;
            progIdx <= 8'h00;
            pageRow <= '0;
        end else if (progStart) begin
            busy <= 1'b1;
            busyCnt <= BUSY_LOAD;
            progIdx <= 8'h00;
            pageRow <= addr[setws_pkg::ADDR_W-1:setws_pkg::OFFSET_W];
        end else if (busy) begin
            if (busyCnt == 18'h00000) begin
                busy <= 1'b0;
            end else begin
                busyCnt <= busyCnt - 18'h00001;
            end
            if (progIdx < 8'(setws_pkg::PAGE_BYTES)) begin
                progIdx <= progIdx + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (busy && (progIdx < 8'(setws_pkg::PAGE_BYTES)) && pageMask[progIdx[6:0]]) begin
            mem[{pageRow, progIdx[6:0]}] <= pageBuf[progIdx[6:0]];
        end
    end

    // Avalon-MM slave: one wait cycle per access
    logic busAck;

    assign avsWaitRequest = (avsReq.read || avsReq.write) && !busAck;

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            busAck <= 1'b0;
            avsReadData <= 32'h0000_0000;
        end else if ((avsReq.read || avsReq.write) && !busAck) begin
            busAck <= 1'b1;
            unique case (avsReq.address)
                setws_pkg::REG_CONTROL: avsReadData <= controlReg;
                setws_pkg::REG_STATUS: begin
                    avsReadData <= '0;
                    avsReadData[setws_pkg::STAT_BUSY] <= busy;
                    avsReadData[setws_pkg::STAT_STANDBY] <= (state == setws_pkg::ST_IDLE) && !busy;
                    avsReadData[setws_pkg::STAT_PROTECTED] <= protectEff;
                    avsReadData[setws_pkg::STAT_ADDR_LSB +: setws_pkg::ADDR_W] <= addr;
                end
                default: avsReadData <= 32'h0000_0000;
            endcase
        end else begin
            busAck <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            controlReg <= setws_pkg::CONTROL_RESET;
        end else if (avsReq.write && busAck && (avsReq.address == setws_pkg::REG_CONTROL)
                     && avsReq.byteEnable[0]) begin
            controlReg[setws_pkg::CTRL_SOFT_PROTECT] <= avsReq.writeData[setws_pkg::CTRL_SOFT_PROTECT];
        end
    end

    // Checks
    chk_drive_after_fall: assert property (@(posedge clk_sys) disable iff (!rstSync)
        $changed(sdaOeN) |-> $past(lineEvent))
        else $error("data line changed outside a clock fall");
    chk_start_restarts: assert property (@(posedge clk_sys) disable iff (!rstSync)
        startDet |=> (state == setws_pkg::ST_DEV) && (bitCnt == 4'h0) && sdaOeN)
        else $error("start did not restart address reception");
    chk_stop_standby: assert property (@(posedge clk_sys) disable iff (!rstSync)
        stopDet |=> (state == setws_pkg::ST_IDLE) && sdaOeN)
        else $error("stop did not return to standby");
    chk_mismatch_nack: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (byteDone && (state == setws_pkg::ST_DEV) && (shiftIn[3:1] != deviceSelectStraps))
        |=> (state == setws_pkg::ST_IDLE) && sdaOeN)
        else $error("mismatched select bits were acknowledged");
    chk_type_nibble: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (byteDone && (state == setws_pkg::ST_DEV) && (shiftIn[7:4] != setws_pkg::TYPE_PATTERN))
        |=> (state == setws_pkg::ST_IDLE))
        else $error("wrong type nibble not ignored");
    chk_addr_ack: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (byteDone && (state == setws_pkg::ST_AHI)) |=> !sdaOeN && ackPhase)
        else $error("word address byte not acknowledged");
    chk_idle_released: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (state == setws_pkg::ST_IDLE) |-> sdaOeN)
        else $error("data line driven while unselected");
    chk_busy_no_ack: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (byteDone && (state == setws_pkg::ST_DEV) && busy) |=> sdaOeN [*2])
        else $error("acknowledged while programming");
    chk_protect_blocks: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (stopDet && (state == setws_pkg::ST_WDAT) && protectEff && !busy) |=> !busy)
        else $error("protected write started programming");
    chk_prog_start: assert property (@(posedge clk_sys) disable iff (!rstSync)
        progStart |=> busy && (busyCnt == BUSY_LOAD))
        else $error("programming cycle not loaded with its full time");
    chk_prog_end: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (busy && (busyCnt == 18'h00000)) |=> !busy)
        else $error("programming cycle overran its time");
    chk_page_wrap: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (byteDone && (state == setws_pkg::ST_WDAT))
        |=> (addr[15:7] == $past(addr[15:7])) && (addr[6:0] == 7'($past(addr[6:0]) + 7'h01)))
        else $error("page write address left its page");
    chk_read_incr: assert property (@(posedge clk_sys) disable iff (!rstSync)
        readGo |=> (addr == 16'($past(addr) + 16'h0001)))
        else $error("read address did not advance");
    chk_bus_answer: assert property (@(posedge clk_sys) disable iff (!rstSync)
        (avsReq.read && avsWaitRequest) |=> !avsWaitRequest)
        else $error("bus access not answered in one wait cycle");

    cov_write_prog: cover property (@(posedge clk_sys) disable iff (!rstSync) progStart);
    cov_read_stream: cover property (@(posedge clk_sys) disable iff (!rstSync)
        ackEnd && (state == setws_pkg::ST_RDAT) && !masterAck);
    cov_poll_busy: cover property (@(posedge clk_sys) disable iff (!rstSync)
        byteDone && (state == setws_pkg::ST_DEV) && busy);
    cov_page_wrap: cover property (@(posedge clk_sys) disable iff (!rstSync)
        byteDone && (state == setws_pkg::ST_WDAT) && (addr[6:0] == 7'h7F));

endmodule // setws_eeprom_slave

// ### shared/setws_pkg.sv
// Constants, types and register map of the two-wire serial EEPROM slave
// Functional notes
// - Sample incoming data on bus clock rise; change outgoing data after clock fall.
// - Data line is open-drain: only pull low or release.
// - Selected only when received select bits equal the strapped select inputs.
// - Write-inhibit high refuses every array write; low allows normal operation; the soft-protect bit also refuses writes.
// - Array holds 512 pages of 128 bytes, 65536 bytes total.
// - Random access uses a full 16-bit word address from the controller.
// - Data changes only while clock low, except start and stop.
// - Data fall with clock high is start; detected in every state.
// - Data rise with clock high is stop; ends a transfer.
// - Stop ending a read puts the device into standby.
// - Eight-bit words; device pulls data low on ninth clock to acknowledge.
// - Standby after power-up and after stop once programming finishes.
// - Every operation begins with a device address word after start.
// - Address word upper nibble must be 1010, else ignored.
// - Next three address bits compared each with its own select strap.
// - Address word LSB high requests read, low requests write.
// - Matching address is acknowledged; mismatch gets no acknowledge, back to standby.
// - Page writes up to 128 bytes and partial page writes accepted.
// - Programming cycle completes within five milliseconds of the stop.
// - Page write increments only low seven address bits, wrapping in page.
// - After write stop, programming runs with inputs disabled, no bus response.
// - Address polling during programming acknowledged only after programming ends.
// - Reads stream bytes from whole-array wrapping counter while controller acknowledges.
package setws_pkg;

    // Timing
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int WRITE_TIME_US = 5000;
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_FREQ_HZ / 1_000_000);

    // Array organisation
    localparam int ADDR_W = 16;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_COUNT = 512;
    localparam int OFFSET_W = 7;
    localparam int ROW_W = ADDR_W - OFFSET_W;
    localparam int BYTE_BITS = 8;

    // Device address word
    localparam logic [3:0] TYPE_PATTERN = 4'hA;

    // Register map (byte addresses)
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CTRL_SOFT_PROTECT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam int STAT_BUSY = 0;
    localparam int STAT_STANDBY = 1;
    localparam int STAT_PROTECTED = 2;
    localparam int STAT_ADDR_LSB = 16;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV  = 6'h02,
        ST_AHI  = 6'h04,
        ST_ALO  = 6'h08,
        ST_WDAT = 6'h10,
        ST_RDAT = 6'h20
    } setws_state_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writeData;
        logic [3:0] byteEnable;
    } setws_avs_req_t;

endpackage

// ### testbench/setws_host_model.sv
// Behavioural two-wire bus controller driving clock and data towards the slave
`timescale 1ns/1ns
module setws_host_model (
    // Clock
    input wire logic clk_sys,
    // Bus
    output logic scl,
    output logic sdaPull,
    input wire logic sdaLine
);
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic quarter();
        repeat (4) @(posedge clk_sys);
    endtask

    // Data moves only in the middle of a low clock phase
    task automatic setSda(input logic b);
        quarter();
        sdaPull <= ~b;
        quarter();
    endtask

    task automatic clockBit(input logic b, output logic s);
        setSda(b);
        scl <= 1'b1;
        quarter();
        s = sdaLine;
        quarter();
        scl <= 1'b0;
    endtask

    task automatic startCond();
        setSda(1'b1);
        scl <= 1'b1;
        quarter();
        sdaPull <= 1'b1;
        quarter();
        scl <= 1'b0;
    endtask

    task automatic stopCond();
        setSda(1'b0);
        scl <= 1'b1;
        quarter();
        sdaPull <= 1'b0;
        quarter();
    endtask

    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clockBit(d[i], s);
        clockBit(1'b1, s);
        ack = ~s;
    endtask

    // Acknowledge asks for one more byte, a released line ends the read
    task automatic readByte(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
        clockBit(~ackIt, s);
    endtask

    // Reports whether the line was seen released in every high phase
    task automatic recover(output logic released);
        logic s;
        released = 1'b1;
        repeat (9) begin
            clockBit(1'b1, s);
            released &= s;
        end
        startCond();
    endtask
endmodule // setws_host_model

// ### testbench/testbench.sv
// Self-checking bench for the two-wire EEPROM slave and its status port
`timescale 1ns/1ns
module testbench;
    localparam int PROG = 200;
    localparam logic [2:0] STRAPS = 3'h5;
    logic clk_sys;
    logic rst_n;
    logic sdaOeN;
    logic sdaOut;
    logic [2:0] straps;
    logic writeInhibit;
    setws_pkg::setws_avs_req_t avsReq;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic hostScl;
    logic hostPull;
    logic sdaWire;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    assign sdaWire = hostPull ? 1'b0 : ((sdaOeN === 1'b0) ? sdaOut : 1'b1);

    setws_eeprom_slave #(.WRITE_CYCLES(PROG)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .sclIn(hostScl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .deviceSelectStraps(straps), .writeInhibit(writeInhibit), .avsReq(avsReq),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));

    setws_host_model host (.clk_sys(clk_sys), .scl(hostScl), .sdaPull(hostPull), .sdaLine(sdaWire));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic avsAccess(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        avsReq <= '{address: a, read: ~wr, write: wr, writeData: wd, byteEnable: 4'hF};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitRequest !== 1'b0);
        rd = avsReadData;
        avsReq <= '0;
        check(32'(n), 32'h2);
    endtask

    task automatic sendWord(input logic [7:0] d, input logic expAck);
        logic ack;
        host.writeByte(d, ack);
        check({31'h0, ack}, {31'h0, expAck});
    endtask

    task automatic setAddr(input logic [15:0] a);
        host.startCond();
        sendWord({4'hA, STRAPS, 1'b0}, 1'b1);
        sendWord(a[15:8], 1'b1);
        sendWord(a[7:0], 1'b1);
    endtask

    task automatic memWrite(input logic [15:0] a, input int n, input logic [7:0] base);
        setAddr(a);
        for (int i = 0; i < n; i++) sendWord(base + 8'(i), 1'b1);
        host.stopCond();
    endtask

    task automatic memRead(input logic [15:0] a, input int n, input logic [7:0] base);
        logic [7:0] d;
        setAddr(a);
        host.startCond();
        sendWord({4'hA, STRAPS, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            host.readByte(i < n - 1, d);
            check({24'h0, d}, {24'h0, base + 8'(i)});
        end
        host.stopCond();
    endtask

    task automatic testRegs();
        logic [31:0] rd;
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check(rd, 32'h2);
        avsAccess(1'b0, 4'h8, 32'h0, rd);
        check(rd, 32'h0);
        avsAccess(1'b1, 4'h4, 32'hFFFF_FFFF, rd);
        avsAccess(1'b1, 4'h0, 32'h1, rd);
        avsAccess(1'b0, 4'h0, 32'h0, rd);
        check(rd, 32'h1);
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check(rd, 32'h6);
        avsAccess(1'b1, 4'h0, 32'h0, rd);
        $display("done: registers");
    endtask

    task automatic testPage();
        logic [31:0] rd;
        memWrite(16'h017E, 3, 8'h30);
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check({31'h0, rd[0]}, 32'h1);
        host.startCond();
        sendWord({4'hA, STRAPS, 1'b0}, 1'b0);
        host.stopCond();
        repeat (PROG) @(posedge clk_sys);
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check({30'h0, rd[1:0]}, 32'h2);
        host.startCond();
        sendWord({4'hA, STRAPS, 1'b0}, 1'b1);
        host.stopCond();
        memRead(16'h017E, 2, 8'h30);
        memRead(16'h0100, 1, 8'h32);
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check({rd[31:16], 14'h0, rd[1:0]}, 32'h0101_0002);
        $display("done: page write");
    endtask

    task automatic testSelect();
        logic [31:0] rd;
        for (int s = 0; s < 8; s++) begin
            host.startCond();
            sendWord({4'hA, 3'(s), 1'b0}, 3'(s) == STRAPS);
            host.stopCond();
        end
        host.startCond();
        sendWord({4'hB, STRAPS, 1'b0}, 1'b0);
        sendWord(8'h01, 1'b0);
        host.stopCond();
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check({31'h0, rd[1]}, 32'h1);
        $display("done: selection");
    endtask

    task automatic testInhibit();
        logic [31:0] rd;
        @(posedge clk_sys);
        writeInhibit <= 1'b1;
        memWrite(16'h0100, 1, 8'hC5);
        avsAccess(1'b0, 4'h4, 32'h0, rd);
        check({29'h0, rd[2:0]}, 32'h6);
        @(posedge clk_sys);
        writeInhibit <= 1'b0;
        memRead(16'h0100, 1, 8'h32);
        $display("done: write inhibit");
    endtask

    task automatic testWrap();
        logic rel;
        memWrite(16'hFFFF, 1, 8'h77);
        repeat (PROG + 10) @(posedge clk_sys);
        memWrite(16'h0000, 1, 8'h78);
        repeat (PROG + 10) @(posedge clk_sys);
        host.recover(rel);
        check({31'h0, rel}, 32'h1);
        memRead(16'hFFFF, 2, 8'h77);
        $display("done: read wrap");
    endtask

    initial begin
        rst_n = 1'b0;
        writeInhibit = 1'b0;
        straps = STRAPS;
        avsReq = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        testRegs();
        testPage();
        testSelect();
        testInhibit();
        testWrap();
        print_verdict();
    end
endmodule // testbench
